// ==== shared/sfrsd_pkg.sv ====
// Package of the special register space: offsets, reset values, masks.
// Assumes an 8-bit direct address bus from the core.
package sfrsd_pkg;
  // =========================================================
  // Register offsets
  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADDR_POINTER0_LOW = 8'h82;
  localparam logic [7:0] ADDR_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] ADDR_POINTER1_LOW = 8'h84;
  localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLOCK_SPEED_CONTROL = 8'h8e;
  localparam logic [7:0] ADDR_SPECIAL_WRITE_ENABLE = 8'h8f;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_EXT_IRQ_FLAGS = 8'h91;
  localparam logic [7:0] ADDR_MOVX_UPPER_PAGE = 8'h92;
  localparam logic [7:0] ADDR_PORT0_DIRECTION = 8'h94;
  localparam logic [7:0] ADDR_PORT0_ALTERNATE = 8'h95;
  localparam logic [7:0] ADDR_PORT1_DIRECTION = 8'h96;
  localparam logic [7:0] ADDR_PORT1_ALTERNATE = 8'h97;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_TRANSCEIVER_PORT = 8'ha0;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'ha1;
  localparam logic [7:0] ADDR_CONVERTER_RESULT_HIGH = 8'ha2;
  localparam logic [7:0] ADDR_CONVERTER_RESULT_LOW = 8'ha3;
  localparam logic [7:0] ADDR_CONVERTER_SETUP = 8'ha4;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PULSE_WIDTH_CONTROL = 8'ha9;
  localparam logic [7:0] ADDR_PULSE_WIDTH_DUTY = 8'haa;
  localparam logic [7:0] ADDR_WDT_RTC_HIGH_BYTE = 8'hab;
  localparam logic [7:0] ADDR_WDT_RTC_LOW_BYTE = 8'hac;
  localparam logic [7:0] ADDR_WDT_RTC_ACCESS_CONTROL = 8'had;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hb1;
  localparam logic [7:0] ADDR_SERIAL_PERIPH_DATA = 8'hb2;
  localparam logic [7:0] ADDR_SERIAL_PERIPH_CONTROL = 8'hb3;
  localparam logic [7:0] ADDR_SERIAL_PERIPH_CLOCK_DIV = 8'hb4;
  localparam logic [7:0] ADDR_TICK_DIVIDER = 8'hb5;
  localparam logic [7:0] ADDR_CLOCK_GATING_CONTROL = 8'hb6;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY = 8'hb8;
  localparam logic [7:0] ADDR_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_TIMER2_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_TIMER2_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_TIMER2_COUNT_HIGH = 8'hcd;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] ADDR_EXT_IRQ_CONTROL_WDT = 8'hd8;
  localparam logic [7:0] ADDR_ARITH_MAIN_REGISTER = 8'he0;
  localparam logic [7:0] ADDR_EXT_IRQ_ENABLES = 8'he8;
  localparam logic [7:0] ADDR_MULTIPLY_AUX_REGISTER = 8'hf0;
  localparam logic [7:0] ADDR_EXT_IRQ_PRIORITIES = 8'hf8;
  localparam logic [7:0] ADDR_SILICON_REVISION = 8'hfe;
  localparam logic [7:0] ADDR_RESERVED_TOP = 8'hff;
  localparam logic [7:0] SFR_SPACE_BASE = 8'h80;
  // =========================================================
  // Number of register slots, five of them spares
  localparam int NUM_REGS = 60;
  // =========================================================
  // Fixed-bit masks: FIX = bits that are constant, VAL = their value
  localparam logic [7:0] FIX_POINTER_SELECT = 8'hfe;
  localparam logic [7:0] VAL_POINTER_SELECT = 8'h00;
  localparam logic [7:0] FIX_POWER_CONTROL = 8'h30;
  localparam logic [7:0] VAL_POWER_CONTROL = 8'h30;
  localparam logic [7:0] FIX_SPECIAL_WRITE = 8'hfe;
  localparam logic [7:0] VAL_SPECIAL_WRITE = 8'h00;
  localparam logic [7:0] FIX_EXT_IRQ_FLAGS = 8'h0f;
  localparam logic [7:0] VAL_EXT_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] FIX_INTERRUPT_ENABLE = 8'h40;
  localparam logic [7:0] VAL_INTERRUPT_ENABLE = 8'h00;
  localparam logic [7:0] FIX_INTERRUPT_PRIORITY = 8'hc0;
  localparam logic [7:0] VAL_INTERRUPT_PRIORITY = 8'h80;
  localparam logic [7:0] FIX_EXT_IRQ_CONTROL = 8'h77;
  localparam logic [7:0] VAL_EXT_IRQ_CONTROL = 8'h40;
  localparam logic [7:0] FIX_EXT_IRQ_EN_PRI = 8'he0;
  localparam logic [7:0] VAL_EXT_IRQ_EN_PRI = 8'he0;
  localparam logic [7:0] FIX_NONE = 8'h00;
  // =========================================================
  // Reset values
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_CLOCK_SPEED_CONTROL = 8'h01;
  localparam logic [7:0] RST_MOVX_UPPER_PAGE = 8'h00;
  localparam logic [7:0] RST_TRANSCEIVER_PORT = 8'h80;
  localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h80;
  localparam logic [7:0] RST_CONVERTER_SETUP = 8'h0a;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h02;
  localparam logic [7:0] RST_TICK_DIVIDER = 8'h1d;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // =========================================================
  // Field positions
  localparam int SEL_BIT = 0;
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_W = 3;
  localparam logic [3:0] STRETCH_BASE = 4'h2;
  localparam int PORT1_W = 3;
  // Revision code: arbitrary neutral value
  localparam logic [7:0] SILICON_REVISION_CODE = 8'h00;
endpackage

// ==== design/sfrsd_space_decoder.sv ====
// Special register space decoder for an 8051-style core.
// Assumes a single clock; core supplies direct address, read and write
// strobes; peripherals read register contents from the flat output bus.
//
// Overview of operation
// R01: Constant bits ignore writes, read their value
// R02: Unused bits are stored and read back; they drive regImage but not wdtRtcControl
// R03: Software leaves unassigned addresses unwritten
// R04: Top address 0xFF is reserved, unused
// R05: Power-on and watchdog resets load initial values
// R06: Standard registers keep standard addresses and bits
// R07: Port registers at 0x80/0x90; port1 three bits (all eight bits of 0x90 are stored)
// R08: Second pointer low 0x84, high 0x85
// R09: Watchdog/clock high byte at 0xAB
// R10: Watchdog/clock low byte at 0xAC
// R11: Control at 0xAD steers byte transfer; bit7 unused
// R12: Timer1 count low 0x8B, high 0x8D
// R13: Select bit 0 of 0x86 picks pointer
// R14: External access cycles are two plus field
// R15: Reserved addresses read zero, writes ignored
`timescale 1ns/100ps
module sfrsd_space_decoder #(
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic watchdogReset,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [DATA_W-1:0] sfrWriteData,
  output logic [DATA_W-1:0] sfrReadData,
  output logic [15:0] activePointer,
  output logic pointerSelect,
  output logic [3:0] movxStretchCycles,
  output logic [15:0] timer1Count,
  output logic [15:0] wdtRtcValue,
  output logic [7:0] wdtRtcControl,
  output logic wdtRtcWriteStrobe,
  output logic [DATA_W*sfrsd_pkg::NUM_REGS-1:0] regImage
);

  // =========================================================
  // Address table, fixed masks and reset values per slot
  localparam logic [7:0] ADDRS [sfrsd_pkg::NUM_REGS] = '{
    sfrsd_pkg::ADDR_PORT0_LATCH, sfrsd_pkg::ADDR_STACK_POINTER,
    sfrsd_pkg::ADDR_POINTER0_LOW, sfrsd_pkg::ADDR_POINTER0_HIGH,
    sfrsd_pkg::ADDR_POINTER1_LOW, sfrsd_pkg::ADDR_POINTER1_HIGH,
    sfrsd_pkg::ADDR_POINTER_SELECT, sfrsd_pkg::ADDR_POWER_CONTROL,
    sfrsd_pkg::ADDR_TIMER_CONTROL, sfrsd_pkg::ADDR_TIMER_MODE,
    sfrsd_pkg::ADDR_TIMER0_COUNT_LOW, sfrsd_pkg::ADDR_TIMER1_COUNT_LOW,
    sfrsd_pkg::ADDR_TIMER0_COUNT_HIGH, sfrsd_pkg::ADDR_TIMER1_COUNT_HIGH,
    sfrsd_pkg::ADDR_CLOCK_SPEED_CONTROL,
    sfrsd_pkg::ADDR_SPECIAL_WRITE_ENABLE,
    sfrsd_pkg::ADDR_PORT1_LATCH, sfrsd_pkg::ADDR_EXT_IRQ_FLAGS,
    sfrsd_pkg::ADDR_MOVX_UPPER_PAGE, sfrsd_pkg::ADDR_PORT0_DIRECTION,
    sfrsd_pkg::ADDR_PORT0_ALTERNATE, sfrsd_pkg::ADDR_PORT1_DIRECTION,
    sfrsd_pkg::ADDR_PORT1_ALTERNATE, sfrsd_pkg::ADDR_SERIAL_CONTROL,
    sfrsd_pkg::ADDR_SERIAL_BUFFER, sfrsd_pkg::ADDR_TRANSCEIVER_PORT,
    sfrsd_pkg::ADDR_CONVERTER_CONTROL,
    sfrsd_pkg::ADDR_CONVERTER_RESULT_HIGH,
    sfrsd_pkg::ADDR_CONVERTER_RESULT_LOW,
    sfrsd_pkg::ADDR_CONVERTER_SETUP, sfrsd_pkg::ADDR_INTERRUPT_ENABLE,
    sfrsd_pkg::ADDR_PULSE_WIDTH_CONTROL,
    sfrsd_pkg::ADDR_PULSE_WIDTH_DUTY,
    sfrsd_pkg::ADDR_WDT_RTC_HIGH_BYTE, sfrsd_pkg::ADDR_WDT_RTC_LOW_BYTE,
    sfrsd_pkg::ADDR_WDT_RTC_ACCESS_CONTROL, sfrsd_pkg::ADDR_RESET_CAUSE,
    sfrsd_pkg::ADDR_SERIAL_PERIPH_DATA,
    sfrsd_pkg::ADDR_SERIAL_PERIPH_CONTROL,
    sfrsd_pkg::ADDR_SERIAL_PERIPH_CLOCK_DIV,
    sfrsd_pkg::ADDR_TICK_DIVIDER, sfrsd_pkg::ADDR_CLOCK_GATING_CONTROL,
    sfrsd_pkg::ADDR_INTERRUPT_PRIORITY, sfrsd_pkg::ADDR_TIMER2_CONTROL,
    sfrsd_pkg::ADDR_TIMER2_RELOAD_LOW, sfrsd_pkg::ADDR_TIMER2_RELOAD_HIGH,
    sfrsd_pkg::ADDR_TIMER2_COUNT_LOW, sfrsd_pkg::ADDR_TIMER2_COUNT_HIGH,
    sfrsd_pkg::ADDR_PROGRAM_STATUS_WORD,
    sfrsd_pkg::ADDR_EXT_IRQ_CONTROL_WDT,
    sfrsd_pkg::ADDR_ARITH_MAIN_REGISTER, sfrsd_pkg::ADDR_EXT_IRQ_ENABLES,
    sfrsd_pkg::ADDR_MULTIPLY_AUX_REGISTER,
    sfrsd_pkg::ADDR_EXT_IRQ_PRIORITIES, sfrsd_pkg::ADDR_SILICON_REVISION,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };
  // Slots 55..59 are spares and never match (their hit is tied low)
  localparam int NUM_USED = 55;

  // Constant bits per slot (read-only slots are flagged separately)
  function automatic logic [7:0] fixMask(input int i);
    logic [7:0] a;
    a = ADDRS[i];
    unique case (a)
      sfrsd_pkg::ADDR_POINTER_SELECT: fixMask = sfrsd_pkg::FIX_POINTER_SELECT;
      sfrsd_pkg::ADDR_POWER_CONTROL: fixMask = sfrsd_pkg::FIX_POWER_CONTROL;
      sfrsd_pkg::ADDR_SPECIAL_WRITE_ENABLE:
        fixMask = sfrsd_pkg::FIX_SPECIAL_WRITE;
      sfrsd_pkg::ADDR_EXT_IRQ_FLAGS: fixMask = sfrsd_pkg::FIX_EXT_IRQ_FLAGS;
      sfrsd_pkg::ADDR_INTERRUPT_ENABLE:
        fixMask = sfrsd_pkg::FIX_INTERRUPT_ENABLE;
      sfrsd_pkg::ADDR_INTERRUPT_PRIORITY:
        fixMask = sfrsd_pkg::FIX_INTERRUPT_PRIORITY;
      sfrsd_pkg::ADDR_EXT_IRQ_CONTROL_WDT:
        fixMask = sfrsd_pkg::FIX_EXT_IRQ_CONTROL;
      sfrsd_pkg::ADDR_EXT_IRQ_ENABLES,
      sfrsd_pkg::ADDR_EXT_IRQ_PRIORITIES:
        fixMask = sfrsd_pkg::FIX_EXT_IRQ_EN_PRI;
      default: fixMask = sfrsd_pkg::FIX_NONE;
    endcase
  endfunction

  // Values of the constant bits per slot
  function automatic logic [7:0] fixValue(input int i);
    logic [7:0] a;
    a = ADDRS[i];
    unique case (a)
      sfrsd_pkg::ADDR_POWER_CONTROL: fixValue = sfrsd_pkg::VAL_POWER_CONTROL;
      sfrsd_pkg::ADDR_EXT_IRQ_FLAGS: fixValue = sfrsd_pkg::VAL_EXT_IRQ_FLAGS;
      sfrsd_pkg::ADDR_INTERRUPT_PRIORITY:
        fixValue = sfrsd_pkg::VAL_INTERRUPT_PRIORITY;
      sfrsd_pkg::ADDR_EXT_IRQ_CONTROL_WDT:
        fixValue = sfrsd_pkg::VAL_EXT_IRQ_CONTROL;
      sfrsd_pkg::ADDR_EXT_IRQ_ENABLES,
      sfrsd_pkg::ADDR_EXT_IRQ_PRIORITIES:
        fixValue = sfrsd_pkg::VAL_EXT_IRQ_EN_PRI;
      default: fixValue = sfrsd_pkg::RST_ZERO;
    endcase
  endfunction

  // Initial value per slot
  function automatic logic [7:0] resetValue(input int i);
    logic [7:0] a;
    a = ADDRS[i];
    unique case (a)
      sfrsd_pkg::ADDR_PORT0_LATCH, sfrsd_pkg::ADDR_PORT1_LATCH,
      sfrsd_pkg::ADDR_PORT0_DIRECTION, sfrsd_pkg::ADDR_PORT1_DIRECTION:
        resetValue = sfrsd_pkg::RST_PORT;
      sfrsd_pkg::ADDR_STACK_POINTER: resetValue = sfrsd_pkg::RST_STACK_POINTER;
      sfrsd_pkg::ADDR_CLOCK_SPEED_CONTROL:
        resetValue = sfrsd_pkg::RST_CLOCK_SPEED_CONTROL;
      sfrsd_pkg::ADDR_TRANSCEIVER_PORT:
        resetValue = sfrsd_pkg::RST_TRANSCEIVER_PORT;
      sfrsd_pkg::ADDR_CONVERTER_CONTROL:
        resetValue = sfrsd_pkg::RST_CONVERTER_CONTROL;
      sfrsd_pkg::ADDR_CONVERTER_SETUP:
        resetValue = sfrsd_pkg::RST_CONVERTER_SETUP;
      sfrsd_pkg::ADDR_RESET_CAUSE: resetValue = sfrsd_pkg::RST_RESET_CAUSE;
      sfrsd_pkg::ADDR_TICK_DIVIDER: resetValue = sfrsd_pkg::RST_TICK_DIVIDER;
      sfrsd_pkg::ADDR_SILICON_REVISION:
        resetValue = sfrsd_pkg::SILICON_REVISION_CODE;
      default: resetValue = fixValue(i);
    endcase
  endfunction

  // =========================================================
  // Storage and address decode
  logic [7:0] regs [sfrsd_pkg::NUM_REGS];
  logic [sfrsd_pkg::NUM_REGS-1:0] hit;
  logic anyHit;
  logic [7:0] readMux;
  logic wdtHit;

  // One-hot slot match; spare slots and the top address never match
  generate
    for (genvar g = 0; g < sfrsd_pkg::NUM_REGS; g++) begin : gDec
      if (g < NUM_USED) begin : gUsed
        assign hit[g] = (sfrAddr == ADDRS[g]); // R06 R07 R08 R09 R10 R12
      end else begin : gSpare
        assign hit[g] = 1'b0;
      end
    end
  endgenerate
  assign anyHit = |hit; // R04 R15

  // Read selection: unmatched addresses read zero
  always_comb begin
    readMux = 8'h00; // R15
    for (int i = 0; i < sfrsd_pkg::NUM_REGS; i++) begin
      if (hit[i]) begin
        readMux = regs[i];
      end
    end
  end

  // Per-slot write: constant bits forced, others stored except in read-only slots (unused bits kept)
  generate
    for (genvar g = 0; g < sfrsd_pkg::NUM_REGS; g++) begin : gReg
      localparam logic [7:0] FM = fixMask(g);
      localparam logic [7:0] FV = fixValue(g);
      localparam logic [7:0] RV = resetValue(g);
      localparam bit RO = (g < NUM_USED) &&
        ((ADDRS[g] == sfrsd_pkg::ADDR_CONVERTER_RESULT_HIGH) ||
         (ADDRS[g] == sfrsd_pkg::ADDR_CONVERTER_RESULT_LOW) ||
         (ADDRS[g] == sfrsd_pkg::ADDR_SILICON_REVISION));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs[g] <= RV; // R05
        end else if (watchdogReset) begin
          regs[g] <= RV; // R05
        end else if (sfrWrite && hit[g] && !RO) begin
          regs[g] <= (sfrWriteData & ~FM) | (FV & FM); // R01 R02
        end
      end
    end
  endgenerate

  // =========================================================
  // Derived outputs
  logic [7:0] psel;
  logic [7:0] speed;
  logic [15:0] next_activePointer;
  logic [3:0] next_stretch;
  assign psel = regs[6];
  assign speed = regs[14];
  // Pointer choice from select bit
  assign next_activePointer = psel[sfrsd_pkg::SEL_BIT] ?
    {regs[5], regs[4]} : {regs[3], regs[2]}; // R13
  // Access length is base plus the three-bit field
  assign next_stretch = sfrsd_pkg::STRETCH_BASE +
    {1'b0, speed[sfrsd_pkg::STRETCH_LSB +: sfrsd_pkg::STRETCH_W]}; // R14
  assign wdtHit = sfrWrite &&
    (sfrAddr == sfrsd_pkg::ADDR_WDT_RTC_ACCESS_CONTROL);

  // Registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfrReadData <= 8'h00;
      activePointer <= 16'h0000;
      pointerSelect <= 1'b0;
      movxStretchCycles <= sfrsd_pkg::STRETCH_BASE + {1'b0,
        sfrsd_pkg::RST_CLOCK_SPEED_CONTROL[sfrsd_pkg::STRETCH_LSB +:
        sfrsd_pkg::STRETCH_W]}; // R14
      timer1Count <= 16'h0000;
      wdtRtcValue <= 16'h0000;
      wdtRtcControl <= 8'h00;
      wdtRtcWriteStrobe <= 1'b0;
    end else begin
      sfrReadData <= sfrRead ? readMux : 8'h00; // R15
      activePointer <= next_activePointer; // R13
      pointerSelect <= psel[sfrsd_pkg::SEL_BIT]; // R13
      movxStretchCycles <= next_stretch; // R14
      timer1Count <= {regs[13], regs[11]}; // R12
      wdtRtcValue <= {regs[33], regs[34]}; // R09 R10
      wdtRtcControl <= {1'b0, regs[35][6:0]}; // R11
      wdtRtcWriteStrobe <= wdtHit && !watchdogReset; // R11
    end
  end

  // Flat image of all registers for the peripherals
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regImage <= '0;
    end else begin
      for (int i = 0; i < sfrsd_pkg::NUM_REGS; i++) begin
        regImage[i*8 +: 8] <= regs[i];
      end
    end
  end

  // =========================================================
  // Checks
  property p_const_bits;
    @(posedge clk) disable iff (rst)
      (sfrWrite && sfrAddr == sfrsd_pkg::ADDR_POWER_CONTROL) |=>
        ((regs[7] & sfrsd_pkg::FIX_POWER_CONTROL) ==
         sfrsd_pkg::VAL_POWER_CONTROL);
  endproperty
  a_const_bits: assert property (p_const_bits) // R01
    else $error("constant bits changed");

  property p_unused_kept;
    @(posedge clk) disable iff (rst)
      (sfrWrite && sfrAddr == sfrsd_pkg::ADDR_WDT_RTC_ACCESS_CONTROL &&
       !watchdogReset) |=> (regs[35][7] == $past(sfrWriteData[7]));
  endproperty
  a_unused_kept: assert property (p_unused_kept) // R02
    else $error("unused bit not stored");

  property p_wdt_reset;
    @(posedge clk) disable iff (rst)
      watchdogReset |=> (regs[6] == 8'h00 && regs[0] == 8'hff);
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) // R05
    else $error("watchdog reset values wrong");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
      (sfrRead && sfrAddr == sfrsd_pkg::ADDR_RESERVED_TOP) |=>
        (sfrReadData == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // R15
    else $error("reserved address read not zero");

  property p_pointer_sel;
    @(posedge clk) disable iff (rst)
      ##1 (activePointer == ($past(psel[0]) ?
        {$past(regs[5]), $past(regs[4])} :
        {$past(regs[3]), $past(regs[2])}));
  endproperty
  a_pointer_sel: assert property (p_pointer_sel) // R13
    else $error("wrong pointer selected");

  property p_stretch;
    @(posedge clk) disable iff (rst)
      ##1 (movxStretchCycles == 4'(2 + $past(speed[2:0])));
  endproperty
  a_stretch: assert property (p_stretch) // R14
    else $error("stretch count wrong");

  property p_wdt_bytes;
    @(posedge clk) disable iff (rst || watchdogReset)
      (sfrWrite && sfrAddr == sfrsd_pkg::ADDR_WDT_RTC_HIGH_BYTE) |=>
        ##1 (wdtRtcValue[15:8] == $past(sfrWriteData, 2));
  endproperty
  a_wdt_bytes: assert property (p_wdt_bytes) // R09
    else $error("high byte not passed");

  property p_timer1;
    @(posedge clk) disable iff (rst || watchdogReset)
      (sfrWrite && sfrAddr == sfrsd_pkg::ADDR_TIMER1_COUNT_LOW) |=>
        ##1 (timer1Count[7:0] == $past(sfrWriteData, 2));
  endproperty
  a_timer1: assert property (p_timer1) // R12
    else $error("timer1 low byte not passed");

  property p_unassigned_zero;
    @(posedge clk) disable iff (rst)
      (sfrRead && !anyHit) |=> (sfrReadData == 8'h00);
  endproperty
  a_unassigned_zero: assert property (p_unassigned_zero) // R15
    else $error("unassigned address read not zero");

  property p_revision_kept;
    @(posedge clk) disable iff (rst)
      (sfrWrite && sfrAddr == sfrsd_pkg::ADDR_SILICON_REVISION) |=>
        (regs[54] == sfrsd_pkg::SILICON_REVISION_CODE);
  endproperty
  a_revision_kept: assert property (p_revision_kept) // R01
    else $error("revision code changed by write");

  property p_wdt_strobe;
    @(posedge clk) disable iff (rst)
      (wdtHit && !watchdogReset) |=> wdtRtcWriteStrobe;
  endproperty
  a_wdt_strobe: assert property (p_wdt_strobe) // R11
    else $error("control write gave no strobe");

  property p_wdt_low;
    @(posedge clk) disable iff (rst || watchdogReset)
      (sfrWrite && sfrAddr == sfrsd_pkg::ADDR_WDT_RTC_LOW_BYTE) |=>
        ##1 (wdtRtcValue[7:0] == $past(sfrWriteData, 2));
  endproperty
  a_wdt_low: assert property (p_wdt_low) // R10
    else $error("low byte not passed");

endmodule

// ==== verification/sfrsd_core_model.sv ====
// Core-side model: issues direct register reads and writes.
// Assumes one clock; the bench calls its tasks by hierarchical name.
`timescale 1ns/100ps
module sfrsd_core_model (
  input wire logic clk,
  output logic [7:0] sfrAddr,
  output logic sfrWrite,
  output logic sfrRead,
  output logic [7:0] sfrWriteData,
  input wire logic [7:0] sfrReadData
);
  // Set by the bench only where a refused write is the point of a test
  bit allowReserved = 1'b0;

  // =========================================================
  // Idle bus values at time zero
  initial begin
    sfrAddr = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    sfrWriteData = 8'h00;
  end

  // =========================================================
  // One write; address and data are scrambled once the edge has taken it
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rsv);
    if (rsv && !allowReserved) begin
      return;
    end
    @(posedge clk);
    sfrAddr <= a;
    sfrWriteData <= d;
    sfrWrite <= 1'b1;
    @(posedge clk);
    sfrWrite <= 1'b0;
    sfrAddr <= ~a;
    sfrWriteData <= ~d;
  endtask

  // One read; data is taken in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge clk);
    sfrRead <= 1'b0;
    sfrAddr <= ~a;
    @(negedge clk);
    d = sfrReadData;
  endtask
endmodule

// ==== verification/sfrsd_testbench.sv ====
// Self-checking bench for the special register space decoder.
// Assumes the core model drives the access strobes; bench drives resets.
`timescale 1ns/100ps
module testbench;
  logic clk, rst, watchdogReset, sfrWrite, sfrRead, pointerSelect;
  logic wdtRtcWriteStrobe;
  logic [7:0] sfrAddr, sfrWriteData, sfrReadData, wdtRtcControl;
  logic [15:0] activePointer, timer1Count, wdtRtcValue;
  logic [3:0] movxStretchCycles;
  logic [8*sfrsd_pkg::NUM_REGS-1:0] regImage;
  int errorCnt = 0;
  int checkCount = 0;
  int hits;
  logic [7:0] d;
  // Address and reset value pairs
  localparam logic [15:0] RST_TAB [0:17] = '{16'h80ff, 16'h8107,
    16'h8600, 16'h8730, 16'h8e01, 16'h9108, 16'h90ff, 16'h94ff, 16'ha080,
    16'ha180, 16'ha40a, 16'hb102, 16'hb51d, 16'hb880, 16'hd840, 16'he8e0,
    16'hf8e0, 16'hab00};
  // Address, constant-bit mask and constant value
  localparam logic [23:0] FIX_TAB [0:8] = '{24'h86fe00, 24'h873030,
    24'h8ffe00, 24'h910f08, 24'ha84000, 24'hb8c080, 24'hd87740,
    24'he8e0e0, 24'hf8e0e0};
  // Plain storage places
  localparam logic [7:0] RW_TAB [0:13] = '{8'h80, 8'h81, 8'h88, 8'h89,
    8'h8a, 8'h8c, 8'h90, 8'h96, 8'h98, 8'h99, 8'hd0, 8'he0, 8'hf0, 8'hc8};

  sfrsd_space_decoder i_sfrsd_space_decoder (
    .clk(clk),
    .rst(rst),
    .watchdogReset(watchdogReset),
    .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite),
    .sfrRead(sfrRead),
    .sfrWriteData(sfrWriteData),
    .sfrReadData(sfrReadData),
    .activePointer(activePointer),
    .pointerSelect(pointerSelect),
    .movxStretchCycles(movxStretchCycles),
    .timer1Count(timer1Count),
    .wdtRtcValue(wdtRtcValue),
    .wdtRtcControl(wdtRtcControl),
    .wdtRtcWriteStrobe(wdtRtcWriteStrobe),
    .regImage(regImage)
  );

  sfrsd_core_model i_core (
    .clk(clk),
    .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite),
    .sfrRead(sfrRead),
    .sfrWriteData(sfrWriteData),
    .sfrReadData(sfrReadData)
  );

  // =========================================================
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // =========================================================
  // Compare tasks and closing
  task automatic checkRead(input string what, input logic [7:0] a,
                           input logic [7:0] exp);
    logic [7:0] got;
    i_core.rd(a, got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s @%h expected %h seen %h", what, a, exp, got);
    end
  endtask

  task automatic checkOut(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Let a write reach the derived outputs
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic reportAndStop;
    $display("Checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // =========================================================
  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    reportAndStop();
  end

  // =========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    watchdogReset = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    checkOut("stretch reset", 16'h0003, {12'h000, movxStretchCycles});
    checkOut("spare slot", 16'h0000, {8'h00, regImage[8*55+:8]});
    foreach (RST_TAB[i]) begin
      checkRead("reset value", RST_TAB[i][15:8], RST_TAB[i][7:0]);
    end
    // Constant bits under all-ones and all-zeros writes
    foreach (FIX_TAB[i]) begin
      for (int k = 0; k < 2; k++) begin
        d = (k == 0) ? 8'hff : 8'h00;
        i_core.wr(FIX_TAB[i][23:16], d, 1'b0);
        checkRead("fixed bits", FIX_TAB[i][23:16],
          (d & ~FIX_TAB[i][15:8]) | FIX_TAB[i][7:0]);
      end
    end
    foreach (RW_TAB[i]) begin
      i_core.wr(RW_TAB[i], RW_TAB[i] ^ 8'h3c, 1'b0);
      checkRead("storage", RW_TAB[i], RW_TAB[i] ^ 8'h3c);
    end
    // Dual pointers and selection
    i_core.wr(8'h82, 8'h11, 1'b0);
    i_core.wr(8'h83, 8'h22, 1'b0);
    i_core.wr(8'h84, 8'h33, 1'b0);
    i_core.wr(8'h85, 8'h44, 1'b0);
    settle();
    checkOut("pointer 0 active", 16'h2211, activePointer);
    i_core.wr(8'h86, 8'h01, 1'b0);
    settle();
    checkOut("select bit", 16'h0001, {15'h0000, pointerSelect});
    checkOut("pointer 1 active", 16'h4433, activePointer);
    checkRead("pointer 1 low", 8'h84, 8'h33);
    checkRead("pointer 1 high", 8'h85, 8'h44);
    // Stretch field, every value
    for (int f = 0; f < 8; f++) begin
      i_core.wr(8'h8e, 8'(f), 1'b0);
      settle();
      checkOut("stretch", 16'(2 + f), {12'h000, movxStretchCycles});
    end
    // Timer 1 and watchdog/clock bytes
    i_core.wr(8'h8b, 8'h5a, 1'b0);
    i_core.wr(8'h8d, 8'ha5, 1'b0);
    i_core.wr(8'hab, 8'hc3, 1'b0);
    i_core.wr(8'hac, 8'h3c, 1'b0);
    settle();
    checkOut("timer1 count", 16'ha55a, timer1Count);
    checkOut("wdt value", 16'hc33c, wdtRtcValue);
    checkRead("wdt high", 8'hab, 8'hc3);
    checkRead("wdt low", 8'hac, 8'h3c);
    i_core.wr(8'had, 8'hff, 1'b0);
    hits = 0;
    repeat (3) begin
      @(negedge clk);
      if (wdtRtcWriteStrobe === 1'b1) begin
        hits++;
      end
    end
    checkOut("wdt strobe pulses", 16'h0001, hits[15:0]);
    checkOut("wdt control", 16'h007f, {8'h00, wdtRtcControl});
    // Refused writes and unassigned reads
    i_core.allowReserved = 1'b1;
    i_core.wr(8'h93, 8'hff, 1'b1);
    i_core.wr(8'hff, 8'hff, 1'b1);
    i_core.wr(8'hfe, 8'h5a, 1'b0);
    checkRead("unassigned", 8'h93, 8'h00);
    checkRead("top address", 8'hff, 8'h00);
    checkRead("revision", 8'hfe, sfrsd_pkg::SILICON_REVISION_CODE);
    checkRead("neighbour low", 8'h92, 8'h00);
    checkRead("neighbour high", 8'h94, 8'hff);
    @(negedge clk);
    checkOut("idle read data", 16'h0000, {8'h00, sfrReadData});
    // Watchdog reset restores initial values
    i_core.wr(8'he0, 8'h55, 1'b0);
    @(posedge clk);
    watchdogReset <= 1'b1;
    @(posedge clk);
    watchdogReset <= 1'b0;
    checkRead("acc after wdt", 8'he0, 8'h00);
    checkRead("stretch after wdt", 8'h8e, 8'h01);
    checkOut("select after wdt", 16'h0000, {15'h0000, pointerSelect});
    reportAndStop();
  end
endmodule
